/* File: verilog/nfs_pkg.sv */
package nfs_pkg;
   // clock and bus timing, figures in ns
   localparam int CLK_NS = 5;
   localparam int WP_NS = 35;
   localparam int WPH_NS = 30;
   localparam int BUSY_NS = 90;
   localparam int RP_NS = 500;
   localparam int RDY_NS = 20000;
   localparam int WIN_NS = 50000;
   // least times round up, the collection window (a longest wait) rounds down
   localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC = (RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RDY_CYC = (RDY_NS + CLK_NS - 1) / CLK_NS;
   localparam int WIN_CYC = WIN_NS / CLK_NS;
   // one whole write cycle, used as the safety margin inside the window
   localparam int WR_CYC = WP_CYC + WPH_CYC + 2;

   localparam int ADDR_W = 22;
   localparam int DATA_W = 8;
   localparam int SECT_LSB = 16;

   localparam logic [21:0] UNLOCK_ADDR1 = 22'h000555;
   localparam logic [21:0] UNLOCK_ADDR2 = 22'h0002aa;
   localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
   localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_PROG = 8'ha0;
   localparam logic [7:0] CMD_BYPASS = 8'h20;
   localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
   localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP = 8'h10;
   localparam logic [7:0] CMD_SECT = 8'h30;
   localparam logic [7:0] CMD_RESET = 8'hf0;

   // write cycles per operation
   localparam logic [2:0] LEN_PROG = 3'h4;
   localparam logic [2:0] LEN_BYP_ENTER = 3'h3;
   localparam logic [2:0] LEN_BYP_PROG = 3'h2;
   localparam logic [2:0] LEN_BYP_EXIT = 3'h2;
   localparam logic [2:0] LEN_ERASE = 3'h6;

   typedef enum logic [2:0]
   {
      OP_PROG = 3'h0,
      OP_BYP_ENTER = 3'h1,
      OP_BYP_PROG = 3'h2,
      OP_BYP_EXIT = 3'h3,
      OP_CHIP = 3'h4,
      OP_SECT = 3'h5,
      OP_RESET = 3'h6
   } nfs_op_t;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h0,
      ST_SETUP = 4'h1,
      ST_STROBE = 4'h2,
      ST_HOLD = 4'h3,
      ST_GAP = 4'h4,
      ST_COLLECT = 4'h5,
      ST_SETTLE = 4'h6,
      ST_POLL = 4'h7,
      ST_RESET = 4'h8,
      ST_RECOVER = 4'h9
   } nfs_state_t;

   typedef struct packed
   {
      nfs_op_t op;
      logic [21:0] addr;
      logic [7:0] data;
   } nfs_req_t;

   typedef struct packed
   {
      logic [21:0] addr;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic reset_n;
      logic speedup;
   } nfs_pins_t;
endpackage : nfs_pkg

/* File: verilog/nfs_host.sv */
// Overview of operation
// R1 - byte program: two unlocks, setup, address/data
// R2 - device times program pulses itself
// R3 - device returns to read after program
// R4 - progress shown on status bits, ready_busy_n
// R5 - commands ignored while programming; reset aborts
// R6 - program any order; only ones become zeros
// R7 - bypass entry: two unlocks then 20h
// R8 - bypass program: A0h then address/data, repeatable
// R9 - bypass mode accepts only bypass program/reset
// R10 - bypass exit: 90h then 00h
// R11 - speedup level forces bypass; never during erase
// R12 - chip erase: six writes ending 10h
// R13 - device preprograms zeros before erase
// R14 - chip erase ignores commands; reset aborts
// R15 - erase status bits; read mode after
// R16 - sector erase: six writes, sector address, 30h
// R17 - 50 us window collects more sectors
// R18 - extra sector writes spaced under 50 us
// R19 - other command in window aborts erase
// R20 - window expiry flagged; restarts each accepted write
// R21 - running sector erase accepts only suspend
// R22 - mismatched write abandons sequence to read
// R23 - address at later fall, data first rise
// R24 - reset command only before embedded operation
// R25 - sector chosen by sector select bits only
// R26 - ready_busy_n low while embedded algorithm runs
`timescale 1ns/100ps
module nfs_host
#(
   parameter int WIN_CYC = nfs_pkg::WIN_CYC,
   parameter int RDY_CYC = nfs_pkg::RDY_CYC
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // user requests
   input wire logic req_valid,
   input wire nfs_pkg::nfs_req_t req,
   output logic req_ready,
   output logic req_err,
   output logic done,
   output logic busy,
   input wire logic hw_reset_req,
   input wire logic acc_mode,
   // flash pins
   output nfs_pkg::nfs_pins_t pins,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic [7:0] dq_in,
   input wire logic ready_busy_n
);
   initial
   begin
      if (WIN_CYC <= nfs_pkg::WR_CYC + 1 || WIN_CYC > 65535 || RDY_CYC < 1 || RDY_CYC > 65535)
         $error("nfs_host: timing parameter out of range");
   end

   nfs_pkg::nfs_state_t state;
   nfs_pkg::nfs_req_t cur;
   logic [15:0] cnt;
   logic [15:0] win_cnt;
   logic [2:0] step;
   logic [2:0] last;
   logic [2:0] wr_cnt;
   logic byp_mode;
   logic [21:0] addr_q;
   logic take;
   logic legal;
   logic win_open;
   logic bypass;
   logic erase_op;

   function automatic logic [29:0] step_word(nfs_pkg::nfs_req_t r, logic [2:0] s);
      logic [21:0] sa;
      logic [29:0] w;
      sa = {r.addr[21:nfs_pkg::SECT_LSB], 16'h0000}; // R25
      w = {nfs_pkg::UNLOCK_ADDR1, nfs_pkg::CMD_RESET};
      unique case (r.op)
         nfs_pkg::OP_PROG, nfs_pkg::OP_BYP_PROG, nfs_pkg::OP_BYP_ENTER:
         begin
            unique case (s)
               3'h0: w = {nfs_pkg::UNLOCK_ADDR1, nfs_pkg::CMD_UNLOCK1}; // R1 R7
               3'h1: w = {nfs_pkg::UNLOCK_ADDR2, nfs_pkg::CMD_UNLOCK2};
               3'h2: w = {nfs_pkg::UNLOCK_ADDR1, (r.op == nfs_pkg::OP_BYP_ENTER) ? nfs_pkg::CMD_BYPASS
                                                                              : nfs_pkg::CMD_PROG}; // R8
               default: w = {r.addr, r.data};
            endcase
         end
         nfs_pkg::OP_BYP_EXIT:
            w = {nfs_pkg::UNLOCK_ADDR1, (s == 3'h0) ? nfs_pkg::CMD_BYP_EXIT1 : nfs_pkg::CMD_BYP_EXIT2}; // R10
         nfs_pkg::OP_CHIP, nfs_pkg::OP_SECT:
         begin
            unique case (s)
               3'h0, 3'h3: w = {nfs_pkg::UNLOCK_ADDR1, nfs_pkg::CMD_UNLOCK1}; // R12 R16
               3'h1, 3'h4: w = {nfs_pkg::UNLOCK_ADDR2, nfs_pkg::CMD_UNLOCK2};
               3'h2: w = {nfs_pkg::UNLOCK_ADDR1, nfs_pkg::CMD_ERASE_SETUP};
               default: w = (r.op == nfs_pkg::OP_CHIP) ? {nfs_pkg::UNLOCK_ADDR1, nfs_pkg::CMD_CHIP}
                                                       : {sa, nfs_pkg::CMD_SECT};
            endcase
         end
         default: w = {nfs_pkg::UNLOCK_ADDR1, nfs_pkg::CMD_RESET};
      endcase
      return w;
   endfunction : step_word

   // the device enters bypass by itself while the speedup level is applied
   assign bypass = byp_mode | acc_mode; // R11
   assign erase_op = cur.op == nfs_pkg::OP_CHIP || cur.op == nfs_pkg::OP_SECT;
   // margin of one write so the extra sector lands before the device closes the window
   assign win_open = win_cnt < 16'(WIN_CYC - nfs_pkg::WR_CYC); // R18

   always_comb
   begin
      legal = 1'b1;
      if (bypass)
         legal = req.op == nfs_pkg::OP_BYP_PROG || (req.op == nfs_pkg::OP_BYP_EXIT && !acc_mode); // R9
      else if (req.op == nfs_pkg::OP_BYP_PROG || req.op == nfs_pkg::OP_BYP_EXIT)
         legal = 1'b0;
      if (acc_mode && (req.op == nfs_pkg::OP_CHIP || req.op == nfs_pkg::OP_SECT))
         legal = 1'b0; // R11
   end

   // nothing but another sector may be written inside the window, or the erase is lost
   assign req_ready = !hw_reset_req && (state == nfs_pkg::ST_IDLE
                      || (state == nfs_pkg::ST_COLLECT && req.op == nfs_pkg::OP_SECT && win_open)); // R19
   assign take = req_valid && req_ready;
   assign busy = state != nfs_pkg::ST_IDLE;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= nfs_pkg::ST_IDLE;
         cnt <= 16'h0000;
         step <= 3'h0;
         last <= 3'h0;
         cur <= '0;
         req_err <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         req_err <= 1'b0;
         done <= 1'b0;
         if (hw_reset_req)
         begin
            state <= nfs_pkg::ST_RESET; // R5 R14 R21
            cnt <= 16'h0000;
         end
         else
         begin
            unique case (state)
               nfs_pkg::ST_IDLE, nfs_pkg::ST_COLLECT:
               begin
                  if (take && state == nfs_pkg::ST_COLLECT)
                  begin
                     cur <= req;
                     step <= 3'h5; // R17
                     last <= 3'h5;
                     state <= nfs_pkg::ST_SETUP;
                  end
                  else if (take && !legal)
                     req_err <= 1'b1;
                  else if (take)
                  begin
                     cur <= req;
                     state <= nfs_pkg::ST_SETUP;
                     unique case (req.op)
                        nfs_pkg::OP_PROG: {step, last} <= {3'h0, nfs_pkg::LEN_PROG - 3'h1};
                        nfs_pkg::OP_BYP_ENTER: {step, last} <= {3'h0, nfs_pkg::LEN_BYP_ENTER - 3'h1};
                        nfs_pkg::OP_BYP_PROG: {step, last} <= {3'h2, 3'h3};
                        nfs_pkg::OP_BYP_EXIT: {step, last} <= {3'h0, nfs_pkg::LEN_BYP_EXIT - 3'h1};
                        nfs_pkg::OP_CHIP, nfs_pkg::OP_SECT: {step, last} <= {3'h0, nfs_pkg::LEN_ERASE - 3'h1};
                        default: {step, last} <= {3'h0, 3'h0}; // R24
                     endcase
                  end
                  else if (state == nfs_pkg::ST_COLLECT && win_cnt >= 16'(WIN_CYC - 1))
                  begin
                     state <= nfs_pkg::ST_SETTLE; // R20
                     cnt <= 16'h0000;
                  end
               end
               nfs_pkg::ST_SETUP:
               begin
                  state <= nfs_pkg::ST_STROBE; // R23
                  cnt <= 16'h0000;
               end
               nfs_pkg::ST_STROBE:
               begin
                  cnt <= cnt + 16'h0001;
                  if (cnt == 16'(nfs_pkg::WP_CYC - 1))
                     state <= nfs_pkg::ST_HOLD;
               end
               nfs_pkg::ST_HOLD:
               begin
                  state <= nfs_pkg::ST_GAP;
                  cnt <= 16'h0000;
               end
               nfs_pkg::ST_GAP:
               begin
                  cnt <= cnt + 16'h0001;
                  if (cnt == 16'(nfs_pkg::WPH_CYC - 1))
                  begin
                     cnt <= 16'h0000;
                     step <= step + 3'h1;
                     if (step != last)
                        state <= nfs_pkg::ST_SETUP;
                     else if (cur.op == nfs_pkg::OP_SECT)
                        state <= nfs_pkg::ST_COLLECT;
                     else if (cur.op == nfs_pkg::OP_PROG || cur.op == nfs_pkg::OP_BYP_PROG || cur.op == nfs_pkg::OP_CHIP)
                        state <= nfs_pkg::ST_SETTLE;
                     else
                     begin
                        state <= nfs_pkg::ST_IDLE;
                        done <= 1'b1;
                     end
                  end
               end
               nfs_pkg::ST_SETTLE:
               begin
                  // ready_busy_n only falls some time after the last strobe
                  cnt <= cnt + 16'h0001;
                  if (cnt == 16'(nfs_pkg::BUSY_CYC - 1))
                     state <= nfs_pkg::ST_POLL;
               end
               nfs_pkg::ST_POLL:
               begin
                  if (ready_busy_n) // R4 R26
                  begin
                     state <= nfs_pkg::ST_IDLE;
                     done <= 1'b1;
                  end
               end
               nfs_pkg::ST_RESET:
               begin
                  cnt <= cnt + 16'h0001;
                  if (cnt == 16'(nfs_pkg::RP_CYC - 1))
                  begin
                     state <= nfs_pkg::ST_RECOVER;
                     cnt <= 16'h0000;
                  end
               end
               nfs_pkg::ST_RECOVER:
               begin
                  cnt <= cnt + 16'h0001;
                  if (cnt == 16'(RDY_CYC - 1))
                     state <= nfs_pkg::ST_IDLE;
               end
               default: state <= nfs_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // window timer restarts at the rising strobe of each sector write
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         win_cnt <= 16'h0000;
      else if (state == nfs_pkg::ST_HOLD && cur.op == nfs_pkg::OP_SECT)
         win_cnt <= 16'h0000; // R20
      else if (state == nfs_pkg::ST_COLLECT || state == nfs_pkg::ST_GAP)
         win_cnt <= win_cnt + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         byp_mode <= 1'b0;
      else if (state == nfs_pkg::ST_RESET)
         byp_mode <= 1'b0;
      else if (done && cur.op == nfs_pkg::OP_BYP_ENTER)
         byp_mode <= 1'b1; // R7
      else if (done && cur.op == nfs_pkg::OP_BYP_EXIT)
         byp_mode <= 1'b0; // R10
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         addr_q <= 22'h000000;
         dq_out <= 8'h00;
      end
      else if (state == nfs_pkg::ST_SETUP)
         {addr_q, dq_out} <= step_word(cur, step);
   end

   // write counter seen only by the checks below
   always_ff @(posedge clk)
   begin
      if (!rst_n || take)
         wr_cnt <= 3'h0;
      else if (state == nfs_pkg::ST_HOLD)
         wr_cnt <= wr_cnt + 3'h1;
   end

   always_comb
   begin
      pins.addr = addr_q;
      pins.ce_n = !(state == nfs_pkg::ST_SETUP || state == nfs_pkg::ST_STROBE || state == nfs_pkg::ST_HOLD);
      pins.we_n = state != nfs_pkg::ST_STROBE;
      pins.oe_n = 1'b1;
      pins.reset_n = state != nfs_pkg::ST_RESET;
      pins.speedup = acc_mode && !(busy && erase_op); // R11
   end
   assign dq_oe = !pins.ce_n;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence strobe_s;
      !pins.we_n [*7];
   endsequence
   sequence hold_s;
      pins.we_n && !pins.ce_n;
   endsequence

   we_pulse_a: assert property ($fell(pins.we_n) |-> strobe_s ##1 hold_s) // R23
      else $error("write strobe width wrong");
   ce_covers_a: assert property (!pins.we_n |-> !pins.ce_n && dq_oe && pins.oe_n) // R23
      else $error("write strobe outside chip select");
   prog_len_a: assert property (done && cur.op == nfs_pkg::OP_PROG |-> wr_cnt == 3'h4) // R1
      else $error("byte program not four writes");
   bypass_len_a: assert property (done && cur.op == nfs_pkg::OP_BYP_PROG |-> wr_cnt == 3'h2 && bypass) // R8
      else $error("bypass program length wrong");
   exit_cmd_a: assert property (done && cur.op == nfs_pkg::OP_BYP_EXIT |-> $past(dq_out) == 8'h00 ##1 !byp_mode) // R10
      else $error("bypass exit wrong");
   enter_len_a: assert property (done && cur.op == nfs_pkg::OP_BYP_ENTER |-> wr_cnt == 3'h3 ##1 byp_mode) // R7
      else $error("bypass entry wrong");
   erase_len_a: assert property (state == nfs_pkg::ST_SETTLE && $past(state) == nfs_pkg::ST_GAP
                                 && cur.op == nfs_pkg::OP_CHIP |-> wr_cnt == 3'h6 && dq_out == 8'h10) // R12
      else $error("chip erase sequence wrong");
   sector_cmd_a: assert property (state == nfs_pkg::ST_HOLD && cur.op == nfs_pkg::OP_SECT && step == 3'h5
                                  |-> dq_out == 8'h30 && addr_q[15:0] == 16'h0000) // R16
      else $error("sector erase write wrong");
   window_hold_a: assert property (state == nfs_pkg::ST_COLLECT && req.op != nfs_pkg::OP_SECT |-> !req_ready) // R19
      else $error("foreign command offered in erase window");
   sector_spacing_a: assert property (take && state == nfs_pkg::ST_COLLECT |-> win_cnt < 16'(WIN_CYC)) // R18
      else $error("extra sector too late");
   // the device ignores writes while its algorithm runs, so one sent then would be lost
   no_write_busy_a: assert property (!ready_busy_n |-> pins.we_n) // R5
      else $error("write while device busy");
   speed_erase_a: assert property (pins.speedup |-> !(busy && erase_op)) // R11
      else $error("speedup during erase");
   reset_pulse_a: assert property ($fell(pins.reset_n) |-> !pins.reset_n [*8]) // R14
      else $error("hardware reset too short");
endmodule : nfs_host

/* File: verilog/nfs_unused_placeholder_never.sv */
`timescale 1ns/100ps

/* File: testbench/nfs_flash_model.sv */
`timescale 1ns/100ps
module nfs_flash_model
#(
   parameter int BUSY_CYC = 40,
   parameter int WIN_CYC = 150
)
(
   // clock that samples the write strobes and times the embedded algorithms
   input wire logic clk,
   // flash pins
   input wire nfs_pkg::nfs_pins_t pins,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   output logic [7:0] dq_in,
   output logic ready_busy_n,
   // observation of what the device accepted
   output int prog_cnt,
   output int chip_cnt,
   output logic [21:0] last_pa,
   output logic [7:0] last_pd,
   output logic [63:0] sect_mask,
   output logic bypass
);
   logic wr;
   logic wr_q;
   logic collect;
   logic alt;
   logic byp;
   logic [21:0] la;
   logic [7:0] d;
   logic [2:0] step;
   int busy_cnt;
   int win_cnt;

   initial
   begin
      {wr_q, collect, alt, bypass, step, la, last_pa, last_pd, sect_mask} = '0;
      {prog_cnt, chip_cnt, busy_cnt, win_cnt} = '0;
   end

   assign wr = ~pins.ce_n & ~pins.we_n;
   assign d = dq_out;
   assign byp = bypass | pins.speedup;
   assign ready_busy_n = (busy_cnt == 0);
   // a released bus shows a changing pattern so stale data never looks valid
   assign dq_in = (pins.oe_n | dq_oe) ? ({8{alt}} ^ 8'h5a) : 8'hff;

   always @(posedge clk)
   begin
      wr_q <= wr;
      alt <= ~alt;
      if (busy_cnt > 0)
         busy_cnt <= busy_cnt - 1;
      if (collect)
         win_cnt <= win_cnt + 1;
      if (collect && win_cnt >= WIN_CYC)
      begin
         collect <= 1'b0;
         busy_cnt <= BUSY_CYC;
      end
      if (wr && !wr_q)
         la <= pins.addr;
      if (!wr && wr_q && busy_cnt == 0)
      begin
         step <= 3'h0;
         if (collect)
         begin
            if (d == 8'h30)
            begin
               sect_mask[la[21:16]] <= 1'b1;
               win_cnt <= 0;
            end
            else
               collect <= 1'b0;
         end
         else if (step == 3'h3)
         begin
            prog_cnt <= prog_cnt + 1;
            last_pa <= la;
            last_pd <= d;
            busy_cnt <= BUSY_CYC;
         end
         else if (step == 3'h7)
         begin
            if (d == 8'h00)
               bypass <= 1'b0;
         end
         else if (byp)
            step <= (d == 8'ha0) ? 3'h3 : ((d == 8'h90) ? 3'h7 : 3'h0);
         else
            case (step)
               3'h0: if (d == 8'haa) step <= 3'h1;
               3'h1: if (d == 8'h55) step <= 3'h2;
               3'h2:
               begin
                  step <= (d == 8'ha0) ? 3'h3 : ((d == 8'h80) ? 3'h4 : 3'h0);
                  if (d == 8'h20)
                     bypass <= 1'b1;
               end
               3'h4: if (d == 8'haa) step <= 3'h5;
               3'h5: if (d == 8'h55) step <= 3'h6;
               default:
               begin
                  if (d == 8'h10)
                  begin
                     chip_cnt <= chip_cnt + 1;
                     busy_cnt <= BUSY_CYC;
                  end
                  else if (d == 8'h30)
                  begin
                     collect <= 1'b1;
                     win_cnt <= 0;
                     sect_mask <= 64'h1 << la[21:16];
                  end
               end
            endcase
      end
      if (!pins.reset_n)
      begin
         {busy_cnt, win_cnt} <= '0;
         {collect, bypass, step} <= '0;
      end
   end
endmodule : nfs_flash_model

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
   logic clk, rst_n, req_valid, req_ready, req_err, done, busy, hw_reset_req, acc_mode;
   logic dq_oe, ready_busy_n, bypass;
   nfs_pkg::nfs_req_t req;
   nfs_pkg::nfs_pins_t pins;
   logic [7:0] dq_out, dq_in, last_pd;
   logic [21:0] last_pa;
   logic [63:0] sect_mask;
   int prog_cnt, chip_cnt, base_d, base_e;
   int error_cnt = 0;
   int compares = 0;
   int done_cnt = 0;
   int rerr_cnt = 0;
   int cyc = 0;

   nfs_host #(.WIN_CYC(200), .RDY_CYC(20)) i_nfs_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .req_err(req_err), .done(done), .busy(busy),
      .hw_reset_req(hw_reset_req), .acc_mode(acc_mode), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
      .dq_in(dq_in), .ready_busy_n(ready_busy_n));
   // the model's window must match the shortened one the host is built with
   nfs_flash_model #(.WIN_CYC(200)) i_nfs_flash_model (.clk(clk), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
      .dq_in(dq_in),
      .ready_busy_n(ready_busy_n), .prog_cnt(prog_cnt), .chip_cnt(chip_cnt), .last_pa(last_pa),
      .last_pd(last_pd), .sect_mask(sect_mask), .bypass(bypass));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic results();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   // whole run needs well under 10000 cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      done_cnt <= done_cnt + int'(done === 1'b1);
      rerr_cnt <= rerr_cnt + int'(req_err === 1'b1);
      if (cyc == 30000)
      begin
         error_cnt++;
         results();
      end
   end

   task automatic chk_val(input string name, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_val

   task automatic chk_bit(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   task automatic start_op(input nfs_pkg::nfs_op_t op, input logic [21:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      base_d = done_cnt;
      base_e = rerr_cnt;
      req_valid <= 1'b1;
      req <= '{op, a, d};
      @(negedge clk);
      for (n = 0; n < 3000 && req_ready !== 1'b1; n++)
         @(negedge clk);
      @(posedge clk);
      req_valid <= 1'b0;
   endtask : start_op

   // an op ends in exactly one of done or req_err; the device must be idle by then
   task automatic op_wait(input logic exp_err);
      int n;
      for (n = 0; n < 3000 && done_cnt == base_d && rerr_cnt == base_e; n++)
         @(negedge clk);
      chk_val("outcome", {62'h0, exp_err, ~exp_err}, {62'h0, rerr_cnt != base_e, done_cnt != base_d});
      chk_bit("busy", 1'b0, busy);
      chk_bit("ready_busy_n", 1'b1, ready_busy_n);
   endtask : op_wait

   task automatic check_prog(input int cnt, input logic [21:0] a, input logic [7:0] d);
      chk_val("prog_cnt", 64'(cnt), 64'(prog_cnt));
      chk_val("prog_addr", {42'h0, a}, {42'h0, last_pa});
      chk_val("prog_data", {56'h0, d}, {56'h0, last_pd});
   endtask : check_prog

   initial
   begin
      int n;
      nfs_pkg::nfs_op_t bad_ops[4];
      bad_ops = '{nfs_pkg::OP_PROG, nfs_pkg::OP_BYP_ENTER, nfs_pkg::OP_CHIP, nfs_pkg::OP_SECT};
      {rst_n, req_valid, hw_reset_req, acc_mode} = '0;
      req = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      start_op(nfs_pkg::OP_PROG, 22'h123456, 8'h3c);
      op_wait(1'b0);
      check_prog(1, 22'h123456, 8'h3c);
      start_op(nfs_pkg::OP_BYP_PROG, 22'h000010, 8'h11);
      op_wait(1'b1);
      start_op(nfs_pkg::OP_BYP_ENTER, 22'h000000, 8'h00);
      op_wait(1'b0);
      chk_bit("bypass", 1'b1, bypass);
      for (n = 0; n < 2; n++)
      begin
         start_op(nfs_pkg::OP_BYP_PROG, 22'h3f0000 + 22'(n), 8'h0f ^ 8'(n));
         op_wait(1'b0);
         check_prog(2 + n, 22'h3f0000 + 22'(n), 8'h0f ^ 8'(n));
      end
      foreach (bad_ops[i])
      begin
         start_op(bad_ops[i], 22'h000020, 8'h00);
         op_wait(1'b1);
      end
      start_op(nfs_pkg::OP_BYP_EXIT, 22'h000000, 8'h00);
      op_wait(1'b0);
      chk_bit("bypass", 1'b0, bypass);
      @(posedge clk);
      acc_mode <= 1'b1;
      repeat (2) @(negedge clk);
      chk_bit("speedup", 1'b1, pins.speedup);
      start_op(nfs_pkg::OP_BYP_PROG, 22'h000100, 8'h55);
      op_wait(1'b0);
      check_prog(4, 22'h000100, 8'h55);
      start_op(nfs_pkg::OP_CHIP, 22'h000000, 8'h00);
      op_wait(1'b1);
      start_op(nfs_pkg::OP_BYP_EXIT, 22'h000000, 8'h00);
      op_wait(1'b1);
      @(posedge clk);
      acc_mode <= 1'b0;
      start_op(nfs_pkg::OP_RESET, 22'h000000, 8'h00);
      op_wait(1'b0);
      start_op(nfs_pkg::OP_CHIP, 22'h000000, 8'h00);
      op_wait(1'b0);
      chk_val("chip_cnt", 64'h1, 64'(chip_cnt));
      start_op(nfs_pkg::OP_SECT, 22'h051234, 8'h00);
      start_op(nfs_pkg::OP_SECT, 22'h2affff, 8'h00);
      op_wait(1'b0);
      chk_val("sect_mask", 64'h0000_0400_0000_0020, sect_mask);
      start_op(nfs_pkg::OP_PROG, 22'h010000, 8'haa);
      for (n = 0; n < 500 && ready_busy_n !== 1'b0; n++)
         @(negedge clk);
      chk_bit("ready_busy_n", 1'b0, ready_busy_n);
      @(posedge clk);
      hw_reset_req <= 1'b1;
      @(posedge clk);
      hw_reset_req <= 1'b0;
      @(negedge clk);
      for (n = 0; n < 2000 && busy !== 1'b0; n++)
         @(negedge clk);
      chk_val("abort_done", 64'(base_d), 64'(done_cnt));
      chk_bit("ready_busy_n", 1'b1, ready_busy_n);
      start_op(nfs_pkg::OP_PROG, 22'h010001, 8'h0a);
      op_wait(1'b0);
      check_prog(6, 22'h010001, 8'h0a);
      results();
   end
endmodule : testbench
